// file: core/mon_adc_seq.v
/*
 Converter sequencer top: setup, scaling and sense result registers,
 mode decoding, per-channel conversion timing and averaging.
 Assumes the serial front end delivers one-cycle REG_WR and REG_RD
 strobes on REF_CLK, and that the converter front end holds
 ADC_SAMPLE valid in the cycle its conversion time ends.
*/
`timescale 1ns/1ns
`include "mon_defines.vh"

module mon_adc_seq #(
    parameter         CW    = 20,
    parameter integer CYC_0 = `MON_CT0_US * `MON_CLK_MHZ,
    parameter integer CYC_1 = `MON_CT1_US * `MON_CLK_MHZ,
    parameter integer CYC_2 = `MON_CT2_US * `MON_CLK_MHZ,
    parameter integer CYC_3 = `MON_CT3_US * `MON_CLK_MHZ,
    parameter integer CYC_4 = `MON_CT4_US * `MON_CLK_MHZ,
    parameter integer CYC_5 = `MON_CT5_US * `MON_CLK_MHZ,
    parameter integer CYC_6 = `MON_CT6_US * `MON_CLK_MHZ,
    parameter integer CYC_7 = `MON_CT7_US * `MON_CLK_MHZ,
    parameter         DW    = 16,
    parameter         AW    = 26
)(
    input  wire          REF_CLK,
    input  wire          RST_B,
    input  wire [7:0]    REG_ADDR,
    input  wire [15:0]   REG_WDATA,
    input  wire          REG_WR,
    input  wire          REG_RD,
    output wire [15:0]   REG_RDATA,
    input  wire          SENSE_RANGE_SELECT,
    input  wire [DW-1:0] ADC_SAMPLE,
    output wire          CONV_START,
    output wire [1:0]    CONV_CHAN,
    output wire          CONV_ACTIVE,
    output wire          CONV_READY,
    output wire          ADC_RANGE,
    output wire [14:0]   CURRENT_SCALE,
    output wire [DW-1:0] BUS_RESULT,
    output wire [DW-1:0] TEMP_RESULT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_POST = 2'h2;

    reg  [15:0]          setup_ff;
    reg  [14:0]          scale_ff;
    reg  [15:0]          rdata_ff;
    reg  [1:0]           state_ff;
    reg  [1:0]           ch_ff;
    reg  [9:0]           round_ff;
    reg                  go_ff;
    reg                  range_ff;
    reg                  conv_start_ff;
    reg  [1:0]           conv_chan_ff;
    reg                  conv_active_ff;
    reg                  conv_ready_ff;

    reg  [1:0]           nxt_state;
    reg  [1:0]           nxt_ch;
    reg  [9:0]           nxt_round;
    reg                  nxt_go;
    reg                  tmr_start;
    reg                  tmr_abort;
    reg  [2:0]           tmr_code;
    reg                  acc_clear;
    reg  [2:0]           acc_add;
    reg                  acc_load;
    reg                  set_start;
    reg  [3:0]           avg_shift;
    reg  [2:0]           en;
    reg  [1:0]           first_ch;
    reg  [1:0]           nxt_chan;
    reg                  has_nxt;
    reg  [15:0]          rd_mux;

    wire                 tmr_done;
    wire [3*DW-1:0]      ch_result;
    wire [3:0]           mode;
    wire                 continuous;
    wire                 shutdown;
    wire [10:0]          rounds;
    wire [10:0]          rounds_m1;
    wire                 round_last;
    wire                 setup_wr;
    wire                 scale_wr;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign mode       = setup_ff[`MON_MODE_MSB:`MON_MODE_LSB];
    assign continuous = setup_ff[`MON_MODE_CONT];

    always @*
    begin
        // Eh would read as temp+sense by bit pattern but means all three
        if (mode == `MON_MODE_ALL_E)
            en = `MON_EN_ALL;
        else
            en = setup_ff[`MON_MODE_EN_MSB:`MON_MODE_LSB];
    end

    // Codes 0h and 8h leave no channel enabled
    assign shutdown = (en == `MON_EN_NONE);

    // Fixed order within a round: bus, sense, temperature
    always @*
    begin
        if (en[`MON_CH_BUS])
            first_ch = `MON_CH_BUS;
        else if (en[`MON_CH_SENSE])
            first_ch = `MON_CH_SENSE;
        else
            first_ch = `MON_CH_TEMP;
    end

    always @*
    begin
        has_nxt  = 1'b0;
        nxt_chan = ch_ff;
        if (ch_ff < `MON_CH_SENSE && en[`MON_CH_SENSE])
        begin
            has_nxt  = 1'b1;
            nxt_chan = `MON_CH_SENSE;
        end
        else if (ch_ff < `MON_CH_TEMP && en[`MON_CH_TEMP])
        begin
            has_nxt  = 1'b1;
            nxt_chan = `MON_CH_TEMP;
        end
    end

    // ------------------------------------------------------------
    // Averaging count
    // ------------------------------------------------------------
    always @*
    begin
        case (setup_ff[`MON_AVG_MSB:`MON_AVG_LSB])
            3'h0:    avg_shift = `MON_AVG_SH0;
            3'h1:    avg_shift = `MON_AVG_SH1;
            3'h2:    avg_shift = `MON_AVG_SH2;
            3'h3:    avg_shift = `MON_AVG_SH3;
            3'h4:    avg_shift = `MON_AVG_SH4;
            3'h5:    avg_shift = `MON_AVG_SH5;
            3'h6:    avg_shift = `MON_AVG_SH6;
            default: avg_shift = `MON_AVG_SH7;
        endcase
    end

    assign rounds     = 11'h001 << avg_shift;
    assign rounds_m1  = rounds - 11'h001;
    assign round_last = (round_ff == rounds_m1[9:0]);

    // ------------------------------------------------------------
    // Conversion time of the channel about to start
    // ------------------------------------------------------------
    always @*
    begin
        case (nxt_ch)
            `MON_CH_BUS:
                tmr_code = setup_ff[`MON_BCT_MSB:`MON_BCT_LSB];
            `MON_CH_SENSE:
                tmr_code = setup_ff[`MON_SCT_MSB:`MON_SCT_LSB];
            default:
                tmr_code = setup_ff[`MON_TCT_MSB:`MON_TCT_LSB];
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign setup_wr = REG_WR && (REG_ADDR == `MON_ADDR_SETUP);
    assign scale_wr = REG_WR && (REG_ADDR == `MON_ADDR_SCALE);

    always @*
    begin
        nxt_state = state_ff;
        nxt_ch    = ch_ff;
        nxt_round = round_ff;
        nxt_go    = go_ff;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        acc_clear = 1'b0;
        acc_add   = 3'h0;
        acc_load  = 1'b0;
        set_start = 1'b0;
        if (setup_wr)
        begin
            // Any setup write drops a running set and rearms
            nxt_go    = 1'b1;
            tmr_abort = 1'b1;
            nxt_state = ST_IDLE;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (go_ff)
                    begin
                        nxt_go = 1'b0;
                        if (!shutdown)
                        begin
                            set_start = 1'b1;
                            acc_clear = 1'b1;
                            nxt_round = 10'h000;
                            nxt_ch    = first_ch;
                            tmr_start = 1'b1;
                            nxt_state = ST_CONV;
                        end
                    end
                end
                ST_CONV:
                begin
                    if (tmr_done)
                    begin
                        acc_add[ch_ff] = 1'b1;
                        if (has_nxt)
                        begin
                            nxt_ch    = nxt_chan;
                            tmr_start = 1'b1;
                        end
                        else if (!round_last)
                        begin
                            nxt_round = round_ff + 10'h001;
                            nxt_ch    = first_ch;
                            tmr_start = 1'b1;
                        end
                        else
                            nxt_state = ST_POST;
                    end
                end
                ST_POST:
                begin
                    acc_load  = 1'b1;
                    acc_clear = 1'b1;
                    if (continuous)
                    begin
                        set_start = 1'b1;
                        nxt_round = 10'h000;
                        nxt_ch    = first_ch;
                        tmr_start = 1'b1;
                        nxt_state = ST_CONV;
                    end
                    else
                        nxt_state = ST_IDLE;
                end
                default:
                    nxt_state = ST_IDLE;
            endcase
        end
    end

    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            state_ff       <= ST_IDLE;
            ch_ff          <= `MON_CH_BUS;
            round_ff       <= 10'h000;
            go_ff          <= 1'b1;
            range_ff       <= 1'b0;
            conv_start_ff  <= 1'b0;
            conv_chan_ff   <= `MON_CH_BUS;
            conv_active_ff <= 1'b0;
            conv_ready_ff  <= 1'b0;
        end
        else
        begin
            state_ff       <= nxt_state;
            ch_ff          <= nxt_ch;
            round_ff       <= nxt_round;
            go_ff          <= nxt_go;
            conv_start_ff  <= tmr_start;
            conv_chan_ff   <= nxt_ch;
            conv_active_ff <= (nxt_state != ST_IDLE);
            conv_ready_ff  <= acc_load;
            // Range held for a whole set so averages never mix scales
            if (set_start)
                range_ff <= SENSE_RANGE_SELECT;
        end
    end

    mon_conv_timer #(
        .CW    (CW),
        .CYC_0 (CYC_0),
        .CYC_1 (CYC_1),
        .CYC_2 (CYC_2),
        .CYC_3 (CYC_3),
        .CYC_4 (CYC_4),
        .CYC_5 (CYC_5),
        .CYC_6 (CYC_6),
        .CYC_7 (CYC_7)
    ) u_timer (
        .clk     (REF_CLK),
        .rst_b   (RST_B),
        .start   (tmr_start),
        .abort   (tmr_abort),
        .code    (tmr_code),
        .done_ff (tmr_done)
    );

    // ------------------------------------------------------------
    // Per-channel averaging
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `MON_NUM_CH; gi = gi + 1)
        begin : g_ch
            mon_avg_acc #(
                .DW (DW),
                .AW (AW)
            ) u_acc (
                .clk       (REF_CLK),
                .rst_b     (RST_B),
                .clear     (acc_clear),
                .add       (acc_add[gi]),
                .sample    (ADC_SAMPLE),
                .shift     (avg_shift),
                .load      (acc_load),
                .result_ff (ch_result[gi*DW +: DW])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always @*
    begin
        case (REG_ADDR)
            `MON_ADDR_SETUP:
                rd_mux = setup_ff;
            `MON_ADDR_SCALE:
                rd_mux = {1'b0, scale_ff};
            `MON_ADDR_SENSE:
                rd_mux = ch_result[DW +: DW];
            default:
                rd_mux = `MON_RD_UNMAPPED;
        endcase
    end

    always @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            setup_ff <= `MON_SETUP_RST;
            scale_ff <= `MON_SCALE_RST;
            rdata_ff <= `MON_RD_UNMAPPED;
        end
        else
        begin
            if (setup_wr)
                setup_ff <= REG_WDATA;
            if (scale_wr)
                scale_ff <= REG_WDATA[`MON_SCALE_MSB:0];
            if (REG_RD)
                rdata_ff <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REG_RDATA     = rdata_ff;
    assign CONV_START    = conv_start_ff;
    assign CONV_CHAN     = conv_chan_ff;
    assign CONV_ACTIVE   = conv_active_ff;
    assign CONV_READY    = conv_ready_ff;
    assign ADC_RANGE     = range_ff;
    // Current math downstream takes its LSB weight from this
    assign CURRENT_SCALE = scale_ff;
    assign BUS_RESULT    = ch_result[0 +: DW];
    assign TEMP_RESULT   = ch_result[2*DW +: DW];

endmodule // mon_adc_seq

// file: core/mon_avg_acc.v
/*
 Per-channel averaging accumulator with its held result register.
 Assumes load is never given in the same cycle as add.
*/
`timescale 1ns/1ns
`include "mon_defines.vh"

module mon_avg_acc #(
    parameter DW = 16,
    parameter AW = 26
)(
    input  wire          clk,
    input  wire          rst_b,
    input  wire          clear,
    input  wire          add,
    input  wire [DW-1:0] sample,
    input  wire [3:0]    shift,
    input  wire          load,
    output reg  [DW-1:0] result_ff
);

    reg  signed [AW-1:0] acc_ff;
    wire signed [AW-1:0] smp_ext = {{(AW-DW){sample[DW-1]}}, sample};
    wire signed [AW-1:0] avg     = acc_ff >>> shift;

    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            acc_ff    <= {AW{1'b0}};
            result_ff <= `MON_RESULT_RST;
        end
        else
        begin
            if (clear)
                acc_ff <= {AW{1'b0}};
            else if (add)
                acc_ff <= acc_ff + smp_ext;
            // Result only moves once the whole run is summed
            if (load)
                result_ff <= avg[DW-1:0];
        end
    end

endmodule // mon_avg_acc

// file: core/mon_conv_timer.v
/*
 Conversion timer: counts one conversion time chosen by a 3-bit
 code and pulses done when it has elapsed.
 Assumes start and abort come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "mon_defines.vh"

module mon_conv_timer #(
    parameter         CW    = 20,
    parameter integer CYC_0 = `MON_CT0_US * `MON_CLK_MHZ,
    parameter integer CYC_1 = `MON_CT1_US * `MON_CLK_MHZ,
    parameter integer CYC_2 = `MON_CT2_US * `MON_CLK_MHZ,
    parameter integer CYC_3 = `MON_CT3_US * `MON_CLK_MHZ,
    parameter integer CYC_4 = `MON_CT4_US * `MON_CLK_MHZ,
    parameter integer CYC_5 = `MON_CT5_US * `MON_CLK_MHZ,
    parameter integer CYC_6 = `MON_CT6_US * `MON_CLK_MHZ,
    parameter integer CYC_7 = `MON_CT7_US * `MON_CLK_MHZ
)(
    input  wire       clk,
    input  wire       rst_b,
    input  wire       start,
    input  wire       abort,
    input  wire [2:0] code,
    output reg        done_ff
);

    reg  [CW-1:0] cnt_ff;
    reg           run_ff;
    reg  [31:0]   load_32;
    wire [CW-1:0] load = load_32[CW-1:0];

    always @*
    begin
        case (code)
            3'h0:    load_32 = CYC_0;
            3'h1:    load_32 = CYC_1;
            3'h2:    load_32 = CYC_2;
            3'h3:    load_32 = CYC_3;
            3'h4:    load_32 = CYC_4;
            3'h5:    load_32 = CYC_5;
            3'h6:    load_32 = CYC_6;
            default: load_32 = CYC_7;
        endcase
    end

    // Done lands load plus one cycles after the cycle that start is given in
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_ff  <= {CW{1'b0}};
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (abort)
                run_ff <= 1'b0;
            else if (start)
            begin
                cnt_ff <= load - {{(CW-1){1'b0}}, 1'b1};
                run_ff <= 1'b1;
            end
            else if (run_ff)
            begin
                if (cnt_ff == {CW{1'b0}})
                begin
                    run_ff  <= 1'b0;
                    done_ff <= 1'b1;
                end
                else
                    cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // mon_conv_timer

// file: dv/mon_adc_front.sv
/* Converter front end model: one sample value per channel while a
   set runs. Assumes the bench changes values only between sets. */
`timescale 1ns/1ns
module mon_adc_front (
    input  wire        clk,
    input  wire        active,
    input  wire [1:0]  chan,
    input  wire [15:0] v0,
    input  wire [15:0] v1,
    input  wire [15:0] v2,
    output reg  [15:0] sample_ff
);
    initial sample_ff = 16'h0000;
    always @(posedge clk)
    begin
        if (active)
            sample_ff <= chan == 2'h0 ? v0 : chan == 2'h1 ? v1 : v2;
        else
            sample_ff <= ~sample_ff; // Idle line never holds stale data
    end
endmodule // mon_adc_front

// file: dv/mon_adc_seq_monitor.sv
/* Checker of the sequencer top ports: register bus, conversion flow
   and result loading. Assumes it is bound into mon_adc_seq. */
`timescale 1ns/1ns
module mon_adc_seq_monitor #(
    parameter DW = 16
)(
    input wire          REF_CLK,
    input wire          RST_B,
    input wire [7:0]    REG_ADDR,
    input wire [15:0]   REG_WDATA,
    input wire          REG_WR,
    input wire          REG_RD,
    input wire [15:0]   REG_RDATA,
    input wire          CONV_START,
    input wire          CONV_ACTIVE,
    input wire          CONV_READY,
    input wire          ADC_RANGE,
    input wire [14:0]   CURRENT_SCALE,
    input wire [DW-1:0] BUS_RESULT
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);
    wire setup_wr = REG_WR && REG_ADDR == 8'h01;

    a_start_single:
    assert property (CONV_START |=> !CONV_START)
        else $error("start pulse longer than one cycle");
    a_start_active:
    assert property (CONV_START |-> CONV_ACTIVE)
        else $error("start while idle");
    a_shutdown_idle:
    assert property (setup_wr && !REG_WDATA[14:12] |=> !CONV_ACTIVE [*3])
        else $error("conversion in shutdown");
    a_write_rearm:
    assert property (setup_wr && REG_WDATA[14:12] |=> !CONV_ACTIVE ##1 CONV_START)
        else $error("setup write did not restart");
    a_scale_mirror:
    assert property (REG_WR && REG_ADDR == 8'h02
        |=> CURRENT_SCALE == $past(REG_WDATA[14:0]))
        else $error("scale output not written value");
    a_scale_top_zero:
    assert property (REG_RD && REG_ADDR == 8'h02 |=> !REG_RDATA[15])
        else $error("scale bit 15 read as one");
    a_rdata_hold:
    assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without read");
    a_result_on_ready:
    assert property (!$stable(BUS_RESULT) |-> CONV_READY)
        else $error("result changed without ready");
    a_range_at_start:
    assert property (!$stable(ADC_RANGE) |-> CONV_START)
        else $error("range changed outside set start");

    c_ready: cover property (CONV_READY);
    c_rearm: cover property (setup_wr ##2 CONV_START);
    c_range: cover property ($rose(ADC_RANGE));
endmodule // mon_adc_seq_monitor

bind mon_adc_seq mon_adc_seq_monitor #(.DW(DW)) i_mon_adc_seq_monitor (.*);

// file: dv/mon_adc_seq_test.sv
/* Self-checking bench of the converter sequencer and front end model.
   Assumes conversion counts shortened to 4 to 11 cycles. */
`timescale 1ns/1ns
module mon_adc_seq_test;
    reg         clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    reg         rng = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [15:0] wdata = 16'h0000, v0 = 16'h0000;
    reg  [15:0] v1 = 16'h0000, v2 = 16'h0000;
    wire [15:0] rdata, smp, bus_r, tmp_r;
    wire [14:0] scale;
    wire [1:0]  chan;
    wire        start, act, rdy, arng;
    integer     n_fail = 0, n_tests = 0, i;
    // Shortest count; each code adds one cycle so gaps stay checkable
    localparam integer CB = 4;

    mon_adc_seq #(.CYC_0(CB), .CYC_1(CB + 1), .CYC_2(CB + 2),
        .CYC_3(CB + 3), .CYC_4(CB + 4), .CYC_5(CB + 5),
        .CYC_6(CB + 6), .CYC_7(CB + 7)) i_mon_adc_seq (
        .REF_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .SENSE_RANGE_SELECT(rng), .ADC_SAMPLE(smp), .CONV_START(start),
        .CONV_CHAN(chan), .CONV_ACTIVE(act), .CONV_READY(rdy),
        .ADC_RANGE(arng), .CURRENT_SCALE(scale), .BUS_RESULT(bus_r),
        .TEMP_RESULT(tmp_r));
    mon_adc_front i_mon_adc_front (.clk(clk), .active(act),
        .chan(chan), .v0(v0), .v1(v1), .v2(v2), .sample_ff(smp));

    initial
    begin
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus cycles and checks
    // ------------------------------------------------------------
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %0s expected %0h seen %0h", nm, exp, seen);
        end
    end
    endtask

    task wrt(input [7:0] a, input [15:0] d);
    begin
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    end
    endtask

    task rdc(input [7:0] a, input [15:0] e);
    begin
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk("rdata", rdata, e);
    end
    endtask

    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // Expected channel order comes from a queue model, start spacing from the time codes
    task run(input [3:0] m, input [2:0] av);
        integer   t, tp, n, c, r;
        reg [2:0] en;
        reg [8:0] ct;
        reg [1:0] lc;
        reg       got;
        integer   q[$];
    begin
        ct = $urandom;
        rng = $urandom;
        v0 = $urandom;
        v1 = $urandom;
        v2 = $urandom;
        q.delete();
        en = m == 4'hE ? 3'h7 : m[2:0];
        for (r = 0; r < (av == 0 ? 1 : av < 4 ? 1 << 2 * av : 1 << av + 3);
            r = r + 1)
            for (c = 0; c < 3; c = c + 1)
                if (en[c])
                    q.push_back(c);
        wrt(8'h01, {m, ct, av});
        n = 0;
        tp = 0;
        lc = 2'h0;
        got = 1'b0;
        for (t = 1; t < (en ? 20000 : 60) && !got; t = t + 1)
        begin
            @(negedge clk);
            if (rdy === 1'b1)
            begin
                got = 1'b1;
                chk("last", t - tp, 6 + ct[8 - 3 * lc -: 3]);
                chk("left", q.size(), 0);
            end
            else if (start === 1'b1)
            begin
                if (n == 0)
                    chk("range", arng, rng);
                else
                    chk("gap", t - tp, 5 + ct[8 - 3 * lc -: 3]);
                chk("chan", chan, q.size() ? q.pop_front() : 9);
                lc = chan;
                tp = t;
                n = n + 1;
            end
        end
        if (en && !got)
        begin
            n_fail = n_fail + 1;
            print_verdict;
        end
        if (!en)
            chk("starts", n, 0);
        if (got)
        begin
            chk("bus", bus_r, en[0] ? v0 : 16'h0000);
            chk("temp", tmp_r, en[2] ? v2 : 16'h0000);
            wrt(8'h04, ~v1);
            rdc(8'h04, en[1] ? v1 : 16'h0000);
        end
        rdc(8'h01, {m, ct, av});
        chk("active", act, m > 4'h8);
    end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        v0 = $urandom(32'hE5F11FDE);
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        rdc(8'h01, 16'hFB68);
        rdc(8'h02, 16'h1000);
        rdc(8'h04, 16'h0000);
        rdc(8'h03, 16'h0000);
        wrt(8'h02, 16'hFFFF);
        rdc(8'h02, 16'h7FFF);
        chk("scale", scale, 15'h7FFF);
        for (i = 0; i < 16; i = i + 1)
            run(i[3:0], 3'h0);
        for (i = 0; i < 8; i = i + 1)
            run(4'hA, i[2:0]);
        print_verdict;
    end
endmodule // mon_adc_seq_test

// file: pkg/mon_defines.vh
/*
 Shared constants of the monitor converter sequencer: register
 addresses, reset values, field positions, mode codes, conversion
 times and averaging shifts.
 Assumes it is included by bare name from each design file.
*/
`ifndef MON_DEFINES_VH
`define MON_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define MON_ADDR_SETUP   8'h01
`define MON_ADDR_SCALE   8'h02
`define MON_ADDR_SENSE   8'h04
`define MON_SETUP_RST    16'hFB68
`define MON_SCALE_RST    15'h1000
`define MON_RESULT_RST   16'h0000
`define MON_RD_UNMAPPED  16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MON_MODE_MSB     15
`define MON_MODE_LSB     12
`define MON_MODE_CONT    15
`define MON_MODE_EN_MSB  14
`define MON_BCT_MSB      11
`define MON_BCT_LSB      9
`define MON_SCT_MSB      8
`define MON_SCT_LSB      6
`define MON_TCT_MSB      5
`define MON_TCT_LSB      3
`define MON_AVG_MSB      2
`define MON_AVG_LSB      0
`define MON_SCALE_MSB    14

// ----------------------------------------------------------------
// Modes and channels
// ----------------------------------------------------------------
`define MON_MODE_ALL_E   4'hE
`define MON_EN_NONE      3'h0
`define MON_EN_ALL       3'h7
`define MON_NUM_CH       3
`define MON_CH_BUS       2'h0
`define MON_CH_SENSE     2'h1
`define MON_CH_TEMP      2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MON_CLK_MHZ      250
`define MON_CT0_US       50
`define MON_CT1_US       84
`define MON_CT2_US       150
`define MON_CT3_US       280
`define MON_CT4_US       540
`define MON_CT5_US       1052
`define MON_CT6_US       2074
`define MON_CT7_US       4120

// ----------------------------------------------------------------
// Averaging: log2 of sample count per code
// ----------------------------------------------------------------
`define MON_AVG_SH0      4'h0
`define MON_AVG_SH1      4'h2
`define MON_AVG_SH2      4'h4
`define MON_AVG_SH3      4'h6
`define MON_AVG_SH4      4'h7
`define MON_AVG_SH5      4'h8
`define MON_AVG_SH6      4'h9
`define MON_AVG_SH7      4'hA

`endif
